// ==== common/cli_pkg.sv ====
package cli_pkg;
  localparam int PC_W = 13;
  localparam int WORD_W = 10;
  localparam int SP_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int ADDR_W = 8;
  localparam int CTRL_WIDE_BIT = 0;

  localparam logic [2:0] OP_BM_HI = 3'h2;
  localparam logic [4:0] OP_BML_HI = 5'h06;
  localparam logic [5:0] OP_LA_HI = 6'h07;
  localparam logic [1:0] OP_LXY_HI = 2'h3;
  localparam logic [1:0] OP_SECOND_HI = 2'h2;
  localparam logic [7:0] OP_IAP_HI = 8'h98;
  localparam logic [1:0] IAP_PORT0 = 2'h0;
  localparam logic [1:0] IAP_PORT1 = 2'h1;
  localparam logic [1:0] IAP_PORT2 = 2'h2;
  localparam logic [9:0] OP_CALL_LONG_INDEXED = 10'h030;
  localparam logic [9:0] OP_BLA = 10'h010;
  localparam logic [9:0] OP_DI = 10'h004;
  localparam logic [9:0] OP_EI = 10'h005;
  localparam logic [9:0] OP_ARM_POWER_DOWN = 10'h05B;
  localparam logic [9:0] OP_POF = 10'h002;
  localparam logic [9:0] OP_RAM_BACKUP_OP = 10'h008;
  localparam logic [9:0] OP_INY = 10'h013;

  localparam logic [5:0] PAGE_TWO = 6'h02;
  localparam logic [5:0] PAGE_THREE = 6'h03;
  localparam logic [6:0] OFF_LAST = 7'h7F;
  localparam logic [12:0] PC_MASK_WIDE = 13'h1FFF;
  localparam logic [12:0] PC_MASK_NARROW = 13'h0FFF;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_STEP = 13'h0001;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [3:0] NIB_ONE = 4'h1;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [2:0] SP_RESET = 3'h7;
  localparam logic [2:0] SP_ONE = 3'h1;
  localparam logic [2:0] D_RESET = 3'h0;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DIDX = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_PC = 8'h0C;
  localparam logic [7:0] REG_TOP = 8'h10;

  typedef enum logic [1:0] {st_fetch, st_second, st_skip2} cli_state_t;

  typedef struct packed {
    logic [13:0] rsvd;
    logic arm;
    logic inte_eff;
    logic inte;
    logic [2:0] sp;
    logic [3:0] y;
    logic [3:0] x;
    logic [3:0] acc;
  } cli_status_t;
endpackage

// ==== rtl/cli_decode.sv ====
`timescale 1ns/10ps
module cli_decode (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cli_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [cli_pkg::WORD_W-1:0] instr_word,
  input wire logic [3:0] port0_pins,
  input wire logic [3:0] port1_pins,
  input wire logic [3:0] port2_pins,
  output logic [cli_pkg::PC_W-1:0] pc_addr,
  output logic [3:0] acc_out,
  output logic irq_accept_en,
  output logic clock_hold_req,
  output logic ram_backup_req
);
  logic [cli_pkg::PC_W-1:0] pc_q;
  logic [cli_pkg::PC_W-1:0] pc_mask;
  logic [cli_pkg::PC_W-1:0] pc_seq;
  logic [cli_pkg::PC_W-1:0] top_word;
  logic [4:0] page_lo_q;
  logic [cli_pkg::SP_W-1:0] sp_q;
  logic [cli_pkg::SP_W-1:0] sp_next;
  logic [2:0] d_idx_q;
  logic [3:0] acc_q;
  logic [3:0] x_q;
  logic [3:0] y_q;
  logic [3:0] y_inc;
  logic inte_q;
  logic inte_eff_q;
  logic arm_q;
  logic skip_q;
  logic last_la_q;
  logic last_lxy_q;
  logic wide_rom_q;
  logic hold_q;
  logic backup_q;
  logic second_push_q;
  logic second_idx_q;
  cli_pkg::cli_state_t state_q;
  logic [cli_pkg::WORD_W-1:0] opc;
  logic is_bm;
  logic is_bml1;
  logic is_two;
  logic is_la;
  logic is_lxy;
  logic is_iap;
  logic fetch_word;
  logic skip_now;
  logic go;
  logic go2;
  logic push;
  logic apb_setup;
  logic apb_write;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  cli_pkg::cli_status_t status;

  assign opc = instr_word;
  assign is_bm = (opc[9:7] == cli_pkg::OP_BM_HI);
  assign is_bml1 = (opc[9:5] == cli_pkg::OP_BML_HI);
  assign is_two = is_bml1 || (opc == cli_pkg::OP_CALL_LONG_INDEXED)
                  || (opc == cli_pkg::OP_BLA);
  assign is_la = (opc[9:4] == cli_pkg::OP_LA_HI);
  assign is_lxy = (opc[9:8] == cli_pkg::OP_LXY_HI);
  assign is_iap = (opc[9:2] == cli_pkg::OP_IAP_HI);
  assign fetch_word = instr_valid && (state_q == cli_pkg::st_fetch);
  assign skip_now = skip_q || (is_la && last_la_q)
                    || (is_lxy && last_lxy_q);
  assign go = fetch_word && !skip_now;
  assign go2 = instr_valid && (state_q == cli_pkg::st_second)
               && (opc[9:8] == cli_pkg::OP_SECOND_HI);
  assign push = (go && is_bm) || (go2 && second_push_q);
  assign sp_next = sp_q + cli_pkg::SP_ONE;
  assign y_inc = y_q + cli_pkg::NIB_ONE;
  // The top page bit only exists on the large ROM.
  assign pc_mask = wide_rom_q ? cli_pkg::PC_MASK_WIDE
                              : cli_pkg::PC_MASK_NARROW;
  // Sequential fetch carries out of the in-page offset into the page field.
  assign pc_seq = (pc_q + cli_pkg::PC_STEP) & pc_mask;

  cli_ret_stack u_stack (
    .clk(pclk),
    .rst_n(presetn),
    .push(push),
    .wr_idx(sp_next),
    .wr_data(pc_seq),
    .rd_idx(sp_q),
    .rd_data(top_word)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= cli_pkg::st_fetch;
      second_push_q <= 1'b0;
      second_idx_q <= 1'b0;
      page_lo_q <= 5'h00;
    end
    else if (fetch_word)
    begin
      if (is_two)
      begin
        state_q <= skip_now ? cli_pkg::st_skip2
                            : cli_pkg::st_second;
      end
      second_push_q <= (opc != cli_pkg::OP_BLA);
      second_idx_q <= !is_bml1;
      page_lo_q <= opc[4:0];
    end
    else if (instr_valid)
    begin
      state_q <= cli_pkg::st_fetch;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_q <= cli_pkg::PC_RESET;
    end
    else if (go && is_bm)
    begin
      pc_q <= {cli_pkg::PAGE_TWO, opc[6:0]} & pc_mask;
    end
    else if (go2 && second_idx_q)
    begin
      pc_q <= {opc[7:6], opc[3:0], d_idx_q, acc_q} & pc_mask;
    end
    else if (go2)
    begin
      pc_q <= {opc[7], page_lo_q, opc[6:0]} & pc_mask;
    end
    else if (instr_valid)
    begin
      pc_q <= pc_seq;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp_q <= cli_pkg::SP_RESET;
    end
    else if (push)
    begin
      sp_q <= sp_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      skip_q <= 1'b0;
      last_la_q <= 1'b0;
      last_lxy_q <= 1'b0;
    end
    else if (fetch_word)
    begin
      skip_q <= go && (opc == cli_pkg::OP_INY)
                && (y_inc == cli_pkg::NIB_ZERO);
      last_la_q <= is_la;
      last_lxy_q <= is_lxy;
    end
    else if (instr_valid)
    begin
      last_la_q <= 1'b0;
      last_lxy_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q <= cli_pkg::NIB_RESET;
    end
    else if (go && is_la)
    begin
      acc_q <= opc[3:0];
    end
    else if (go && is_iap)
    begin
      case (opc[1:0])
        cli_pkg::IAP_PORT0: acc_q <= port0_pins;
        cli_pkg::IAP_PORT1: acc_q <= port1_pins;
        cli_pkg::IAP_PORT2: acc_q <= port2_pins;
        default: acc_q <= acc_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      x_q <= cli_pkg::NIB_RESET;
      y_q <= cli_pkg::NIB_RESET;
    end
    else if (go && is_lxy)
    begin
      x_q <= opc[7:4];
      y_q <= opc[3:0];
    end
    else if (go && (opc == cli_pkg::OP_INY))
    begin
      y_q <= y_inc;
    end
  end

  // The accepted-enable copy trails the flag by one machine cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      inte_q <= 1'b0;
      inte_eff_q <= 1'b0;
    end
    else if (instr_valid)
    begin
      inte_eff_q <= inte_q;
      if (go && (opc == cli_pkg::OP_DI))
      begin
        inte_q <= 1'b0;
      end
      else if (go && (opc == cli_pkg::OP_EI))
      begin
        inte_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arm_q <= 1'b0;
      hold_q <= 1'b0;
      backup_q <= 1'b0;
    end
    else
    begin
      hold_q <= go && arm_q && (opc == cli_pkg::OP_POF);
      backup_q <= go && arm_q && (opc == cli_pkg::OP_RAM_BACKUP_OP);
      if (go)
      begin
        arm_q <= (opc == cli_pkg::OP_ARM_POWER_DOWN);
      end
    end
  end

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready_q && pwrite && !pslverr_q;

  always_comb
  begin
    status = '0;
    status.arm = arm_q;
    status.inte_eff = inte_eff_q;
    status.inte = inte_q;
    status.sp = sp_q;
    status.y = y_q;
    status.x = x_q;
    status.acc = acc_q;
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      cli_pkg::REG_CTRL: rd_mux[cli_pkg::CTRL_WIDE_BIT] = wide_rom_q;
      cli_pkg::REG_DIDX: rd_mux[2:0] = d_idx_q;
      cli_pkg::REG_STAT: rd_mux = status;
      cli_pkg::REG_PC: rd_mux[cli_pkg::PC_W-1:0] = pc_q;
      cli_pkg::REG_TOP: rd_mux[cli_pkg::PC_W-1:0] = top_word;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup && !mapped;
      prdata_q <= (apb_setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wide_rom_q <= 1'b1;
      d_idx_q <= cli_pkg::D_RESET;
    end
    else if (apb_write && (paddr == cli_pkg::REG_CTRL))
    begin
      wide_rom_q <= pwdata[cli_pkg::CTRL_WIDE_BIT];
    end
    else if (apb_write && (paddr == cli_pkg::REG_DIDX))
    begin
      d_idx_q <= pwdata[2:0];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pc_addr = pc_q;
  assign acc_out = acc_q;
  assign irq_accept_en = inte_eff_q;
  assign clock_hold_req = hold_q;
  assign ram_backup_req = backup_q;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_page_two_call: assert property (
    go && is_bm |=> pc_q[12:7] == cli_pkg::PAGE_TWO
      && pc_q[6:0] == $past(opc[6:0]) && sp_q == $past(sp_next))
    else $error("page two call target or push wrong");

  a_page_carry: assert property (
    instr_valid && state_q == cli_pkg::st_fetch && !is_bm && !is_two
      && pc_q == {cli_pkg::PAGE_TWO, cli_pkg::OFF_LAST}
      |=> pc_q[12:7] == cli_pkg::PAGE_THREE && pc_q[6:0] == 7'h00)
    else $error("page two sequential fetch did not carry");

  a_long_call: assert property (
    go2 && second_push_q && !second_idx_q
      |=> pc_q[11:7] == $past(page_lo_q) && pc_q[6:0] == $past(opc[6:0])
      && pc_q[12] == ($past(opc[7]) && $past(wide_rom_q))
      && sp_q == $past(sp_next))
    else $error("long call target wrong");

  a_indexed_call: assert property (
    go2 && second_idx_q
      |=> pc_q[6:0] == {$past(d_idx_q), $past(acc_q)})
    else $error("indexed call offset wrong");

  a_mask_delay: assert property (
    go && opc == cli_pkg::OP_DI && inte_q && inte_eff_q
      |=> !inte_q && inte_eff_q)
    else $error("interrupt mask not delayed by one cycle");

  a_enable_delay: assert property (
    go && opc == cli_pkg::OP_EI && !inte_q
      |=> inte_q && !inte_eff_q)
    else $error("interrupt enable not delayed by one cycle");

  a_power_gate: assert property (
    fetch_word && !arm_q |=> !clock_hold_req && !ram_backup_req)
    else $error("power down acted without arming");

  a_power_armed: assert property (
    go && arm_q && opc == cli_pkg::OP_POF |=> clock_hold_req ##1 !hold_q)
    else $error("armed clock hold not raised for one cycle");

  a_port_read: assert property (
    go && is_iap && opc[1:0] == cli_pkg::IAP_PORT1
      |=> acc_q == $past(port1_pins))
    else $error("port read did not load accumulator");

  a_y_wrap_skip: assert property (
    go && opc == cli_pkg::OP_INY && y_q == 4'hF
      |=> y_q == 4'h0 && skip_q)
    else $error("y wrap did not arm a skip");

  a_la_repeat: assert property (
    fetch_word && is_la && last_la_q |=> $stable(acc_q))
    else $error("repeated immediate load executed");

  a_lxy_repeat: assert property (
    fetch_word && is_lxy && last_lxy_q |=> $stable(x_q) && $stable(y_q))
    else $error("repeated pair load executed");

  a_skip_quiet: assert property (
    fetch_word && skip_q |=> $stable(acc_q) && $stable(sp_q)
      && $stable(inte_q) && state_q != cli_pkg::st_second)
    else $error("skipped instruction changed state");
endmodule

// ==== rtl/cli_ret_stack.sv ====
`timescale 1ns/10ps
module cli_ret_stack (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [cli_pkg::SP_W-1:0] wr_idx,
  input wire logic [cli_pkg::PC_W-1:0] wr_data,
  input wire logic [cli_pkg::SP_W-1:0] rd_idx,
  output logic [cli_pkg::PC_W-1:0] rd_data
);
  logic [cli_pkg::PC_W-1:0] slot_q [cli_pkg::STACK_DEPTH];

  // The index wraps silently; a ninth push overwrites the oldest entry.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < cli_pkg::STACK_DEPTH; i++)
      begin
        slot_q[i] <= cli_pkg::PC_RESET;
      end
    end
    else if (push)
    begin
      slot_q[wr_idx] <= wr_data;
    end
  end

  assign rd_data = slot_q[rd_idx];
endmodule

// ==== verif/cli_prog_mem.sv ====
`timescale 1ns/10ps
module cli_prog_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic slow,
  input wire logic [cli_pkg::PC_W-1:0] pc_addr,
  output logic instr_valid,
  output logic [cli_pkg::WORD_W-1:0] instr_word
);
  logic [cli_pkg::WORD_W-1:0] mem [0:(2**cli_pkg::PC_W)-1];
  logic gap_q;
  logic [cli_pkg::WORD_W-1:0] last_q;

  // In slow mode every other machine cycle carries no word.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gap_q <= 1'b0;
    else
      gap_q <= slow & ~gap_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_q <= 10'h000;
    else
      last_q <= instr_word;
  end

  assign instr_valid = en & ~gap_q;
  // An idle bus flips every cycle, so a stale word is never mistaken for data.
  assign instr_word = instr_valid ? mem[pc_addr] : ~last_q;
endmodule

// ==== verif/test_call_irq_load_instr_decode.sv ====
`timescale 1ns/10ps
module test_call_irq_load_instr_decode;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic en, slow, instr_valid, err;
  logic [9:0] instr_word;
  logic [3:0] pins [0:2];
  logic [3:0] acc_out, n;
  logic [12:0] pc_addr, pc;
  logic irq_accept_en, clock_hold_req, ram_backup_req;
  int failures, checked, hold_cnt, backup_cnt;

  cli_decode u_cli_decode (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .port0_pins(pins[0]), .port1_pins(pins[1]), .port2_pins(pins[2]),
    .pc_addr(pc_addr), .acc_out(acc_out), .irq_accept_en(irq_accept_en),
    .clock_hold_req(clock_hold_req), .ram_backup_req(ram_backup_req));

  cli_prog_mem u_cli_prog_mem (.pclk(pclk), .presetn(presetn), .en(en),
    .slow(slow), .pc_addr(pc_addr), .instr_valid(instr_valid),
    .instr_word(instr_word));

  always #4 pclk = ~pclk;

  always @(posedge pclk)
  begin
    if (clock_hold_req === 1'b1) hold_cnt++;
    if (ram_backup_req === 1'b1) backup_cnt++;
  end

  task summarize();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    // A slave that never answers is a mismatch, not a silent pass.
    if (pready !== 1'b1)
    begin
      failures++;
      $display("[ERR] pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Feeds n words; the partner may stall, so words are counted, not cycles.
  task exec(input int cnt);
    int c, t;
    c = 0;
    t = 0;
    en <= 1'b1;
    while (c < cnt && t < 200)
    begin
      @(posedge pclk);
      t++;
      if (instr_valid === 1'b1) c++;
    end
    en <= 1'b0;
    chk("words", cnt, c);
    @(negedge pclk);
  endtask

  task put(input logic [12:0] a, input logic [9:0] w);
    u_cli_prog_mem.mem[a] = w;
  endtask

  initial
  begin
    #200000;
    failures++;
    summarize();
  end

  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; en = 0; slow = 0;
    failures = 0; checked = 0; hold_cnt = 0; backup_cnt = 0;
    void'($urandom(32'hF874));
    pins[0] = 4'($urandom); pins[1] = 4'h0; pins[2] = 4'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cli_pkg::REG_STAT, 32'h0);
    chk("status", 32'h0000_7000, rd);
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b1, cli_pkg::REG_DIDX, 32'h6);
    apb(1'b0, cli_pkg::REG_DIDX, 32'h0);
    chk("d_index_bits", 32'h6, rd);
    put(0, 10'h075); put(1, 10'h079); put(2, 10'h33F); put(3, 10'h311);
    put(4, 10'h013); put(5, 10'h0C7); put(6, 10'h201); put(7, 10'h005);
    put(8, 10'h260); put(9, 10'h004); put(10, 10'h110);
    put(13'h110, 10'h0C5); put(13'h111, 10'h222);
    put(13'h2A2, 10'h030); put(13'h2A3, 10'h203);
    slow <= 1'b1;
    exec(8);
    chk("irq_en", 32'h0, {31'h0, irq_accept_en});
    chk("pc", 32'h8, {19'h0, pc_addr});
    apb(1'b0, cli_pkg::REG_STAT, 32'h0);
    chk("status", 32'h0000_F035, rd);
    exec(1);
    chk("irq_en", 32'h1, {31'h0, irq_accept_en});
    chk("acc", {28'h0, pins[0]}, {28'h0, acc_out});
    exec(1);
    chk("irq_en", 32'h1, {31'h0, irq_accept_en});
    exec(1);
    chk("irq_en", 32'h0, {31'h0, irq_accept_en});
    chk("pc", 32'h110, {19'h0, pc_addr});
    exec(2);
    chk("pc", {19'h0, 6'd5, 7'h22}, {19'h0, pc_addr});
    exec(2);
    chk("pc", {19'h0, 6'd3, 3'd6, pins[0]}, {19'h0, pc_addr});
    apb(1'b0, cli_pkg::REG_STAT, 32'h0);
    chk("status", {20'h2, 8'h03, pins[0]}, rd);
    apb(1'b0, cli_pkg::REG_TOP, 32'h0);
    chk("stack", 32'h2A4, rd);
    slow <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      n = 4'($urandom);
      pc = pc_addr;
      pins[i % 3] <= 4'($urandom);
      put(pc, {6'h07, n});
      put(pc + 13'h1, {6'h07, ~n});
      put(pc + 13'h2, {cli_pkg::OP_IAP_HI, 2'(i % 3)});
      exec(2);
      chk("acc", {28'h0, n}, {28'h0, acc_out});
      exec(1);
      chk("acc", {28'h0, pins[i % 3]}, {28'h0, acc_out});
    end
    // Nesting stays at five levels, inside the eight-entry stack.
    put(pc_addr, 10'h17F);
    put(13'h17F, cli_pkg::OP_ARM_POWER_DOWN); put(13'h180, cli_pkg::OP_POF);
    put(13'h181, cli_pkg::OP_RAM_BACKUP_OP); put(13'h182, cli_pkg::OP_ARM_POWER_DOWN);
    put(13'h183, cli_pkg::OP_RAM_BACKUP_OP); put(13'h184, cli_pkg::OP_POF);
    exec(7);
    repeat (2) @(negedge pclk);
    chk("pc", 32'h185, {19'h0, pc_addr});
    chk("hold", 32'h1, 32'(hold_cnt));
    chk("backup", 32'h1, 32'(backup_cnt));
    apb(1'b1, cli_pkg::REG_CTRL, 32'h0);
    @(negedge pclk);
    put(pc_addr, 10'h0C1); put(pc_addr + 13'h1, 10'h285);
    exec(2);
    chk("pc", 32'h085, {19'h0, pc_addr});
    summarize();
  end
endmodule
